// file: shared/csm_defines.vh
// Constants shared by the configuration set manager, its assertions and its test bench
//
// Overview of operation
// RQ1 - Board temperature readable from status field
// RQ2 - Working set is volatile, drives operation
// RQ3 - Parameter writes change only the working set
// RQ4 - Factory set is permanent and never altered
// RQ5 - Four persistent user slots take working copies
// RQ6 - Save to slot five or above stores nothing
// RQ7 - Save runs through the bulk save process
// RQ8 - Activate user set copies into working set
// RQ9 - Activated set becomes the linked startup source
// RQ10 - Factory activation copies, applies, relinks startup
// RQ11 - First start after delivery loads factory set
// RQ12 - Reset loads linked set, else factory set
// RQ13 - Download sends set out, upload brings in
// RQ14 - Requested reset behaves like a power cycle; reset_req does not clear the upload FIFO or temp_status
// RQ15 - One operation finishes before the next starts
`ifndef CSM_DEFINES_VH
`define CSM_DEFINES_VH

// =====================================================
// Bulk operation codes
`define CSM_OP_W 2
`define CSM_OP_SAVE 2'h0
`define CSM_OP_ACTIVATE 2'h1
`define CSM_OP_DOWNLOAD 2'h2
`define CSM_OP_UPLOAD 2'h3

// =====================================================
// Slot numbering
`define CSM_SLOT_W 3
`define CSM_SLOT_FACTORY 3'h0
`define CSM_SLOT_FIRST 3'h1
`define CSM_SLOT_LAST 3'h4
`define CSM_USER_SLOTS 4

// =====================================================
// Sizes and reset values
`define CSM_WORDS 16
`define CSM_WIDTH 32
`define CSM_TEMP_W 8
`define CSM_FIFO_DEPTH 32
`define CSM_TEMP_RESET 8'h00

`endif

// file: hdl/csm_fifo.v
// Upload data FIFO with registered full and empty flags
`timescale 1ns/100ps
module csm_fifo
#(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
)
(
  input wire clk_sys,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg not_full;
  reg empty;
  wire push;
  wire pop;
  wire [AW:0] next_count;

  // =====================================================
  // Handshakes
  assign in_ready = not_full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr];
  assign push = in_valid & not_full;
  assign pop = out_ready & ~empty;
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // =====================================================
  // Storage
  always @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // =====================================================
  // Pointers and flags
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      not_full <= 1'b1;
      empty <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      count <= next_count;
      not_full <= (next_count != DEPTH);
      empty <= (next_count == {(AW+1){1'b0}});
    end
  end

endmodule // csm_fifo

// file: hdl/csm_config_set_manager.v
// Configuration set manager: working set, factory set, user slots and bulk processes
`timescale 1ns/100ps
`include "csm_defines.vh"
module csm_config_set_manager
#(
  parameter WORDS = `CSM_WORDS,
  parameter WIDTH = `CSM_WIDTH,
  parameter IW = 4,
  parameter TEMP_W = `CSM_TEMP_W,
  parameter FIFO_DEPTH = `CSM_FIFO_DEPTH,
  parameter FIFO_AW = 5,
  parameter [WORDS*WIDTH-1:0] FACTORY_SET = {(WORDS*WIDTH){1'b0}}
)
(
  input wire clk_sys,
  input wire rst,
  input wire reset_req,
  input wire nv_erase,
  input wire [TEMP_W-1:0] temp_sensor,
  output reg [TEMP_W-1:0] temp_status,
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [`CSM_OP_W-1:0] cmd_op,
  input wire [`CSM_SLOT_W-1:0] cmd_slot,
  output reg cmd_done,
  output reg cmd_err,
  output reg busy,
  input wire par_wr_en,
  input wire [IW-1:0] par_wr_addr,
  input wire [WIDTH-1:0] par_wr_data,
  output reg [WORDS*WIDTH-1:0] work_set,
  output reg [`CSM_SLOT_W-1:0] link_slot,
  output reg dl_valid,
  input wire dl_ready,
  output reg [WIDTH-1:0] dl_data,
  output reg dl_last,
  input wire up_valid,
  output wire up_ready,
  input wire [WIDTH-1:0] up_data
);

  // =====================================================
  // States
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_LOAD = 6'b000010;
  localparam [5:0] S_SAVE = 6'b000100;
  localparam [5:0] S_DNLD = 6'b001000;
  localparam [5:0] S_UPLD = 6'b010000;
  localparam [5:0] S_DONE = 6'b100000;
  localparam MEM_AW = IW + 2;

  reg [5:0] state;
  reg [IW-1:0] idx;
  reg [`CSM_SLOT_W-1:0] op_slot;
  reg op_activate;
  reg [WIDTH-1:0] user_mem [0:`CSM_USER_SLOTS*WORDS-1];
  wire last_word;
  wire fifo_valid;
  wire [WIDTH-1:0] fifo_data;
  wire fifo_pop;
  wire start;
  wire slot_ok;
  wire [WIDTH-1:0] src_word;
  reg ws_wr;
  reg [IW-1:0] ws_sel;
  reg [WIDTH-1:0] ws_word;

  // =====================================================
  // User slot address, slot 1 maps to the first block
  function [MEM_AW-1:0] slot_addr;
    input [`CSM_SLOT_W-1:0] slot;
    input [IW-1:0] word;
    reg [1:0] blk;
    begin
      blk = slot[1:0] - 2'h1;
      slot_addr = {blk, word};
    end
  endfunction

  // =====================================================
  // Word select from a packed parameter set
  function [WIDTH-1:0] word_at;
    input [WORDS*WIDTH-1:0] vec;
    input [IW:0] word;
    begin
      word_at = vec[word*WIDTH +: WIDTH];
    end
  endfunction

  // =====================================================
  // Decode
  assign last_word = (idx == WORDS - 1);
  assign start = cmd_valid & cmd_ready;
  assign slot_ok = (cmd_slot >= `CSM_SLOT_FIRST) && (cmd_slot <= `CSM_SLOT_LAST);
  assign fifo_pop = (state == S_UPLD) & fifo_valid;
  assign src_word = (op_slot == `CSM_SLOT_FACTORY) ? word_at(FACTORY_SET, {1'b0, idx}) :
    user_mem[slot_addr(op_slot, idx)];

  // =====================================================
  // Working set write port, one word per cycle
  always @*
  begin
    ws_wr = 1'b0;
    ws_sel = idx;
    ws_word = src_word;
    case (state)
      S_IDLE:
      begin
        ws_wr = par_wr_en & ~start; // RQ3
        ws_sel = par_wr_addr;
        ws_word = par_wr_data;
      end
      S_LOAD:
      begin
        ws_wr = 1'b1; // RQ8 RQ12
      end
      S_UPLD:
      begin
        ws_wr = fifo_valid; // RQ13
        ws_word = fifo_data;
      end
      default:
      begin
        ws_wr = 1'b0;
      end
    endcase
  end

  // =====================================================
  // Upload FIFO
  csm_fifo
  #(
    .WIDTH(WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  )
  u_fifo
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(up_valid),
    .in_ready(up_ready),
    .in_data(up_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // =====================================================
  // Temperature status
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      temp_status <= `CSM_TEMP_RESET;
    end
    else
    begin
      temp_status <= temp_sensor; // RQ1
    end
  end

  // =====================================================
  // Non-volatile user slots, untouched by reset
  always @(posedge clk_sys)
  begin
    if (state == S_SAVE)
    begin
      user_mem[slot_addr(op_slot, idx)] <= word_at(work_set, {1'b0, idx}); // RQ5
    end
  end

  // =====================================================
  // Non-volatile startup link, untouched by reset; the delivery erase or a factory activation sets it to the factory slot
  always @(posedge clk_sys)
  begin
    if (nv_erase)
    begin
      link_slot <= `CSM_SLOT_FACTORY; // RQ11
    end
    else if (state == S_LOAD && op_activate && last_word)
    begin
      link_slot <= op_slot; // RQ9 RQ10
    end
  end

  // =====================================================
  // Sequencer
  always @(posedge clk_sys)
  begin
    if (rst || reset_req)
    begin
      state <= S_LOAD; // RQ14
      idx <= {IW{1'b0}};
      op_slot <= nv_erase ? `CSM_SLOT_FACTORY : link_slot; // RQ12
      op_activate <= 1'b0;
      work_set <= {(WORDS*WIDTH){1'b0}}; // RQ2
      cmd_ready <= 1'b0;
      cmd_done <= 1'b0;
      cmd_err <= 1'b0;
      busy <= 1'b1;
      dl_valid <= 1'b0;
      dl_data <= {WIDTH{1'b0}};
      dl_last <= 1'b0;
    end
    else
    begin
      cmd_done <= 1'b0;
      cmd_err <= 1'b0;
      if (ws_wr)
      begin
        work_set[ws_sel*WIDTH +: WIDTH] <= ws_word;
      end
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            cmd_ready <= 1'b0; // RQ15
            busy <= 1'b1;
            idx <= {IW{1'b0}};
            op_slot <= cmd_slot;
            op_activate <= 1'b0;
            case (cmd_op)
              `CSM_OP_SAVE:
              begin
                if (slot_ok)
                begin
                  state <= S_SAVE; // RQ7
                end
                else
                begin
                  state <= S_DONE; // RQ6 RQ4
                  cmd_err <= 1'b1;
                end
              end
              `CSM_OP_ACTIVATE:
              begin
                if (slot_ok || cmd_slot == `CSM_SLOT_FACTORY)
                begin
                  state <= S_LOAD; // RQ8 RQ10
                  op_activate <= 1'b1;
                end
                else
                begin
                  state <= S_DONE;
                  cmd_err <= 1'b1;
                end
              end
              `CSM_OP_DOWNLOAD:
              begin
                state <= S_DNLD; // RQ13
              end
              `CSM_OP_UPLOAD:
              begin
                state <= S_UPLD; // RQ13
              end
              default:
              begin
                state <= S_DONE;
                cmd_err <= 1'b1;
              end
            endcase
          end
        end
        S_LOAD:
        begin
          if (last_word)
          begin
            state <= S_DONE;
          end
          else
          begin
            idx <= idx + 1'b1;
          end
        end
        S_SAVE:
        begin
          if (last_word)
          begin
            state <= S_DONE; // RQ15
          end
          else
          begin
            idx <= idx + 1'b1;
          end
        end
        S_DNLD:
        begin
          if (!dl_valid)
          begin
            dl_valid <= 1'b1;
            dl_data <= word_at(work_set, {1'b0, idx});
            dl_last <= last_word;
          end
          else if (dl_ready)
          begin
            if (dl_last)
            begin
              dl_valid <= 1'b0;
              dl_last <= 1'b0;
              state <= S_DONE;
            end
            else
            begin
              idx <= idx + 1'b1;
              dl_data <= word_at(work_set, {1'b0, idx} + 1'b1);
              dl_last <= (idx + 1'b1 == WORDS - 1);
            end
          end
        end
        S_UPLD:
        begin
          if (fifo_valid)
          begin
            if (last_word)
            begin
              state <= S_DONE;
            end
            else
            begin
              idx <= idx + 1'b1;
            end
          end
        end
        S_DONE:
        begin
          state <= S_IDLE;
          cmd_done <= 1'b1;
          cmd_ready <= 1'b1;
          busy <= 1'b0;
          idx <= {IW{1'b0}};
        end
        default:
        begin
          state <= S_IDLE;
          cmd_ready <= 1'b1;
          busy <= 1'b0;
        end
      endcase
    end
  end

endmodule // csm_config_set_manager

// file: verif/csm_sva.sv
// Port assertions for the configuration set manager
`timescale 1ns/100ps
`include "csm_defines.vh"
module csm_sva
#(
  parameter WORDS = 16,
  parameter WIDTH = 32,
  parameter IW = 4,
  parameter TEMP_W = 8
)
(
  input logic clk_sys,
  input logic rst,
  input logic reset_req,
  input logic [TEMP_W-1:0] temp_sensor,
  input logic [TEMP_W-1:0] temp_status,
  input logic cmd_valid,
  input logic cmd_ready,
  input logic [`CSM_OP_W-1:0] cmd_op,
  input logic [`CSM_SLOT_W-1:0] cmd_slot,
  input logic cmd_done,
  input logic cmd_err,
  input logic busy,
  input logic par_wr_en,
  input logic [IW-1:0] par_wr_addr,
  input logic [WIDTH-1:0] par_wr_data,
  input logic [WORDS*WIDTH-1:0] work_set,
  input logic dl_valid,
  input logic dl_ready,
  input logic [WIDTH-1:0] dl_data,
  input logic dl_last
);
  // ==========
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || reset_req);
  wire take = cmd_valid && cmd_ready;
  wire bad = (cmd_op == `CSM_OP_SAVE && (cmd_slot == 3'h0 || cmd_slot > 3'h4))
    || (cmd_op == `CSM_OP_ACTIVATE && cmd_slot > 3'h4);
  property p_temp;
    !$past(rst) && !$past(reset_req) |-> temp_status == $past(temp_sensor);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature copy wrong");
  property p_par;
    !busy && par_wr_en && !take |=> work_set[$past(par_wr_addr)*WIDTH +: WIDTH] == $past(par_wr_data);
  endproperty
  a_par: assert property (p_par) else $error("parameter write lost");
  property p_save;
    take && cmd_op == `CSM_OP_SAVE && !bad |-> ##18 cmd_done && !cmd_err;
  endproperty
  a_save: assert property (p_save) else $error("save timing wrong");
  property p_bad;
    take && bad |=> cmd_err ##1 cmd_done;
  endproperty
  a_bad: assert property (p_bad) else $error("bad slot not refused");
  property p_take;
    take |=> busy && !cmd_ready;
  endproperty
  a_take: assert property (p_take) else $error("second command open");
  property p_ready;
    cmd_ready |-> !busy;
  endproperty
  a_ready: assert property (p_ready) else $error("ready while busy");
  property p_dl;
    dl_valid && !dl_ready |=> dl_valid && $stable(dl_data);
  endproperty
  a_dl: assert property (p_dl) else $error("download word dropped");
  property p_rst;
    disable iff (1'b0) rst || reset_req |=> busy && !cmd_ready && !dl_valid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not taken");
  c_save: cover property (take && cmd_op == `CSM_OP_SAVE);
  c_err: cover property (cmd_err);
  c_last: cover property (dl_valid && dl_ready && dl_last);
endmodule // csm_sva
bind csm_config_set_manager csm_sva #(.WORDS(WORDS), .WIDTH(WIDTH), .IW(IW), .TEMP_W(TEMP_W)) u_csm_sva (.*);

// file: verif/csm_host_model.sv
// Host stream partner: feeds uploads, paces downloads
`timescale 1ns/100ps
module csm_host_model
#(
  parameter [31:0] BASE = 32'hA0000000,
  parameter [5:0] NUM = 6'h21
)
(
  input logic clk_sys,
  input logic rst,
  input logic go,
  input logic up_ready,
  output logic up_valid = 1'h0,
  output logic [31:0] up_data = 32'h0,
  output logic dl_ready = 1'h0
);
  // ==========
  // Streams
  logic [5:0] left = 6'h0;
  always @(posedge clk_sys)
  begin
    dl_ready <= ~dl_ready & ~rst;
    if (rst)
      up_valid <= 1'h0;
    else if (go)
    begin
      left <= NUM;
      up_valid <= 1'h1;
      up_data <= BASE;
    end
    else if (up_valid && up_ready)
    begin
      left <= left - 6'h1;
      up_valid <= left != 6'h1;
      up_data <= (left == 6'h1) ? ~up_data : up_data + 32'h1;
    end
  end
endmodule // csm_host_model

// file: verif/csm_config_set_manager_test.sv
// Self-checking bench for the configuration set manager
`timescale 1ns/100ps
`include "csm_defines.vh"
module csm_config_set_manager_test;
  localparam [511:0] FS = {16{32'hC3C35A5A}};
  reg clk_sys = 1'h0, rst = 1'h1, reset_req = 1'h0, nv_erase = 1'h1, cmd_valid = 1'h0, par_wr_en = 1'h0, go = 1'h0;
  reg [7:0] temp_sensor = 8'h5A;
  reg [1:0] cmd_op = 2'h0;
  reg [2:0] cmd_slot = 3'h0;
  reg [3:0] par_wr_addr = 4'h0;
  reg [31:0] par_wr_data = 32'h0;
  wire cmd_ready, cmd_done, cmd_err, busy, dl_valid, dl_ready, dl_last, up_valid, up_ready;
  wire [7:0] temp_status;
  wire [2:0] link_slot;
  wire [31:0] dl_data, up_data;
  wire [511:0] work_set;
  reg [511:0] ex, s1, s4, dl_buf;
  integer error_cnt = 0, tests_run = 0, cyc = 0, dn = 0, i;
  csm_config_set_manager #(.FACTORY_SET(FS)) u_csm_config_set_manager (.*);
  csm_host_model u_csm_host_model (.*);
  // ==========
  // Clock, timeout, download capture
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (dl_valid === 1'h1 && dl_ready === 1'h1)
    begin
      chk(dl_last, dn == 15);
      dl_buf[dn*32 +: 32] = dl_data;
      dn = dn + 1;
    end
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  task chk(input [511:0] g, input [511:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task end_sim;
    begin
      $display("errors=%0d checks=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task idle;
    begin
      @(negedge clk_sys);
      while (cmd_ready !== 1'h1)
        @(negedge clk_sys);
    end
  endtask
  task cmd(input [1:0] op, input [2:0] sl, input e);
    reg seen;
    begin
      seen = 1'h0;
      idle;
      cmd_valid = 1'h1;
      cmd_op = op;
      cmd_slot = sl;
      @(negedge clk_sys);
      cmd_valid = 1'h0;
      while (cmd_done !== 1'h1)
      begin
        seen = seen | cmd_err;
        @(negedge clk_sys);
      end
      chk(seen, e);
    end
  endtask
  task pw(input [3:0] a, input [31:0] d);
    begin
      idle;
      par_wr_en = 1'h1;
      par_wr_addr = a;
      par_wr_data = d;
      ex[a*32 +: 32] = d;
      @(negedge clk_sys);
      par_wr_en = 1'h0;
    end
  endtask
  task rs(input r);
    begin
      @(negedge clk_sys);
      rst = r;
      reset_req = ~r;
      @(negedge clk_sys);
      rst = 1'h0;
      reset_req = 1'h0;
      idle;
    end
  endtask
  // ==========
  // Scenarios
  task t_boot;
    begin
      repeat (8) @(negedge clk_sys);
      rst = 1'h0;
      nv_erase = 1'h0;
      idle;
      chk(work_set, FS);
      chk(link_slot, 3'h0);
      chk(temp_status, 8'h5A);
      temp_sensor = 8'hA5;
      @(negedge clk_sys);
      chk(temp_status, 8'hA5);
      ex = FS;
    end
  endtask
  task t_save_act;
    begin
      pw(4'h3, 32'h12345678);
      chk(work_set, ex);
      cmd(`CSM_OP_SAVE, 3'h1, 1'h0);
      s1 = ex;
      pw(4'hF, 32'h0BADF00D);
      cmd(`CSM_OP_SAVE, 3'h4, 1'h0);
      s4 = ex;
      cmd(`CSM_OP_SAVE, 3'h5, 1'h1);
      cmd(`CSM_OP_SAVE, 3'h0, 1'h1);
      cmd(`CSM_OP_ACTIVATE, 3'h0, 1'h0);
      chk(work_set, FS);
      cmd(`CSM_OP_ACTIVATE, 3'h4, 1'h0);
      chk(work_set, s4);
      cmd(`CSM_OP_ACTIVATE, 3'h1, 1'h0);
      chk(work_set, s1);
      chk(link_slot, 3'h1);
      cmd(`CSM_OP_ACTIVATE, 3'h5, 1'h1);
      chk(work_set, s1);
    end
  endtask
  task t_reset;
    begin
      pw(4'h0, 32'h00C0FFEE);
      rs(1'h1);
      chk(work_set, s1);
      pw(4'h0, 32'h00C0FFEE);
      rs(1'h0);
      chk(work_set, s1);
      cmd(`CSM_OP_ACTIVATE, 3'h0, 1'h0);
      rs(1'h1);
      chk(work_set, FS);
      chk(link_slot, 3'h0);
      ex = FS;
    end
  endtask
  task t_dl;
    begin
      dn = 0;
      cmd(`CSM_OP_DOWNLOAD, 3'h0, 1'h0);
      chk(dl_buf, ex);
      chk(dn, 16);
    end
  endtask
  task t_up;
    begin
      go = 1'h1;
      @(negedge clk_sys);
      go = 1'h0;
      repeat (40) @(negedge clk_sys);
      chk({up_valid, up_ready}, 2'h2);
      for (i = 0; i < 16; i = i + 1)
        ex[i*32 +: 32] = 32'hA0000000 + i;
      cmd(`CSM_OP_UPLOAD, 3'h0, 1'h0);
      chk(work_set, ex);
      for (i = 0; i < 16; i = i + 1)
        ex[i*32 +: 32] = 32'hA0000010 + i;
      cmd(`CSM_OP_UPLOAD, 3'h0, 1'h0);
      chk(work_set, ex);
      chk(up_valid, 1'h0);
    end
  endtask
  initial
  begin
    t_boot;
    t_save_act;
    t_reset;
    t_dl;
    t_up;
    end_sim;
  end
endmodule // csm_config_set_manager_test
